// ### common/cfr_pkg.sv
// Shared types and constants for the flags, reset and decode core
package cfr_pkg;

  // ---------------------------------------------------------------
  // Operand sizes, instruction groups and reset sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_WORD = 2'b01,
    SZ_LONG = 2'b10
  } cfr_size_t;

  typedef enum logic [3:0] {
    GR_XFER   = 4'b0000,
    GR_ARITH  = 4'b0001,
    GR_LOGIC  = 4'b0010,
    GR_SHIFT  = 4'b0011,
    GR_BIT    = 4'b0100,
    GR_BRANCH = 4'b0101,
    GR_SYS    = 4'b0110,
    GR_BLOCK  = 4'b0111,
    GR_NONE   = 4'b1000
  } cfr_group_t;

  typedef enum logic {
    ST_VEC = 1'b0,
    ST_RUN = 1'b1
  } cfr_state_t;

  // ---------------------------------------------------------------
  // Instruction type indices, grouped in ascending ranges
  // ---------------------------------------------------------------
  localparam logic [6:0] GB_XFER = 7'h00, GB_ARITH = 7'h05, GB_LOGIC = 7'h18;
  localparam logic [6:0] GB_SHIFT = 7'h1C, GB_BIT = 7'h24, GB_BRANCH = 7'h32;
  localparam logic [6:0] GB_SYS = 7'h37, GB_BLOCK = 7'h40, TY_COUNT = 7'h41;
  localparam logic [6:0] TY_MLOAD = 7'h01, TY_MSTORE = 7'h02;
  localparam logic [6:0] TY_PRD = 7'h03, TY_PWR = 7'h04;
  localparam logic [6:0] TY_ADD = 7'h05, TY_SUB = 7'h06, TY_CMP = 7'h07, TY_NEG = 7'h08;
  localparam logic [6:0] TY_ADDX = 7'h09, TY_SUBX = 7'h0A;
  localparam logic [6:0] TY_DADJ_ADD = 7'h0B, TY_DADJ_SUB = 7'h0C;
  localparam logic [6:0] TY_INC = 7'h0D, TY_DEC = 7'h0E, TY_ADDS = 7'h0F, TY_SUBS = 7'h10;
  localparam logic [6:0] TY_EXTU = 7'h15, TY_EXTS = 7'h16, TY_TSET = 7'h17;
  localparam logic [6:0] TY_AND = 7'h18, TY_OR = 7'h19, TY_XOR = 7'h1A, TY_NOT = 7'h1B;
  localparam logic [6:0] TY_SHAL = 7'h1C, TY_SHAR = 7'h1D, TY_SHLL = 7'h1E, TY_SHLR = 7'h1F;
  localparam logic [6:0] TY_ROTL = 7'h20, TY_ROTR = 7'h21, TY_ROTXL = 7'h22, TY_ROTXR = 7'h23;
  localparam logic [6:0] TY_BSET = 7'h24, TY_BCLR = 7'h25, TY_BNOT = 7'h26, TY_BTST = 7'h27;
  localparam logic [6:0] TY_BLD = 7'h28, TY_BILD = 7'h29, TY_BST = 7'h2A, TY_BIST = 7'h2B;
  localparam logic [6:0] TY_BAND = 7'h2C, TY_BIAND = 7'h2D, TY_BOR = 7'h2E, TY_BIOR = 7'h2F;
  localparam logic [6:0] TY_BXOR = 7'h30, TY_BIXOR = 7'h31;
  localparam logic [6:0] TY_TRAPA = 7'h37, TY_LDC = 7'h3A, TY_STC = 7'h3B;
  localparam logic [6:0] TY_ANDC = 7'h3C, TY_ORC = 7'h3D, TY_XORC = 7'h3E;

  // ---------------------------------------------------------------
  // Flag positions, reset values and datapath constants
  // ---------------------------------------------------------------
  localparam int unsigned FLAG_C = 0, FLAG_V = 1, FLAG_I = 7, FLAG_H = 5;
  localparam int unsigned SP_REG_IDX = 7;
  localparam logic        FLAG_I_RST = 1'b1;
  localparam logic        TRACE_RST = 1'b0;
  localparam logic [2:0]  IMASK_RST = 3'h7;
  localparam logic [7:0]  TSET_REG_OK = 8'h33;
  localparam logic [31:0] ALIGN_MASK = 32'hFFFF_FFFE;
  localparam logic [31:0] BYTES_BYTE = 32'h0000_0001;
  localparam logic [31:0] BYTES_WORD = 32'h0000_0002;
  localparam logic [31:0] BYTES_LONG = 32'h0000_0004;
  localparam logic [31:0] MASK_BYTE = 32'h0000_00FF, TOP_BYTE = 32'h0000_0080;
  localparam logic [31:0] MASK_WORD = 32'h0000_FFFF, TOP_WORD = 32'h0000_8000;
  localparam logic [31:0] MASK_LONG = 32'hFFFF_FFFF, TOP_LONG = 32'h8000_0000;
  localparam logic [7:0]  BIT_ONE = 8'h01;
  localparam logic [3:0]  BCD_NIB_MAX = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX = 8'h99;
  localparam logic [7:0]  BCD_LO_FIX = 8'h06, BCD_HI_FIX = 8'h60;

endpackage

// ### src/cfr_alu.sv
// Combinational datapath: arithmetic, decimal adjust, logic, shift and bit operations
`timescale 1ns/1ps
`default_nettype none
module cfr_alu
  import cfr_pkg::*;
(
  input  wire logic [6:0]  op,
  input  wire cfr_size_t   size,
  input  wire logic [31:0] src_a,
  input  wire logic [31:0] src_b,
  input  wire logic        c_in,
  input  wire logic        h_in,
  input  wire logic [2:0]  bit_idx,
  output logic      [31:0] result,
  output logic             c_out,
  output logic             v_out,
  output logic             c_wr,
  output logic             v_wr
);
  logic [31:0] msk, top, lm, am, bm, xo, yo, r, bx;
  logic [32:0] sum, dif, cm;
  logic [7:0]  bsel, fix;
  logic        ci, sa, sb, sr_a, sr_s, msb, lsb, bv, es, is_bit, is_ar, hi_fix;
  cfr_size_t   sz;

  assign is_bit = (op >= GB_BIT) && (op < GB_BRANCH);
  assign is_ar  = (op >= GB_ARITH) && (op < GB_LOGIC);

  // Single-size types ignore the size field so a bad size cannot corrupt them
  always_comb begin
    sz = size;
    if (is_bit || op == TY_ADDX || op == TY_SUBX || op == TY_TSET ||
        op == TY_DADJ_ADD || op == TY_DADJ_SUB) begin
      sz = SZ_BYTE;
    end else if (op == TY_ADDS || op == TY_SUBS) begin
      sz = SZ_LONG;
    end
  end

  // Width masks for byte, word and longword operands
  always_comb begin
    unique case (sz)
      SZ_BYTE: begin
        msk = MASK_BYTE;
        top = TOP_BYTE;
        lm  = MASK_BYTE;
      end
      SZ_WORD: begin
        msk = MASK_WORD;
        top = TOP_WORD;
        lm  = MASK_BYTE;
      end
      default: begin
        msk = MASK_LONG;
        top = TOP_LONG;
        lm  = MASK_WORD;
      end
    endcase
  end

  // Shared adder and subtractor; negate is zero minus the operand
  assign am   = src_a & msk;
  assign bm   = src_b & msk;
  assign xo   = (op == TY_NEG) ? '0 : am;
  assign yo   = (op == TY_NEG) ? am : bm;
  assign ci   = (op == TY_ADDX || op == TY_SUBX) ? c_in : 1'b0;
  assign sum  = {1'b0, xo} + {1'b0, yo} + {32'h0000_0000, ci};
  assign dif  = {1'b0, xo} - {1'b0, yo} - {32'h0000_0000, ci};
  assign cm   = {top, 1'b0};
  assign sa   = |(xo & top);
  assign sb   = |(yo & top);
  assign sr_a = |(sum[31:0] & top);
  assign sr_s = |(dif[31:0] & top);
  assign msb  = |(am & top);
  assign lsb  = am[0];
  assign es   = |(am & (lm ^ (lm >> 1)));
  assign bsel = BIT_ONE << bit_idx;
  assign bx   = {24'h00_0000, bsel};
  assign bv   = |(src_a[7:0] & bsel);

  // Decimal adjust views the byte as two packed BCD digits
  assign hi_fix = (op == TY_DADJ_ADD) ? (c_in || (am[7:0] > BCD_BYTE_MAX)) : c_in;
  assign fix = ((h_in || (op == TY_DADJ_ADD && am[3:0] > BCD_NIB_MAX)) ? BCD_LO_FIX : 8'h00)
             + (hi_fix ? BCD_HI_FIX : 8'h00);

  // Operation select; types not listed below pass the operand through
  always_comb begin
    r     = am;
    c_out = 1'b0;
    v_out = 1'b0;
    c_wr  = 1'b0;
    case (op)
      TY_ADD, TY_ADDX, TY_INC, TY_ADDS: begin
        r     = sum[31:0];
        c_out = |(sum & cm);
        v_out = (sa == sb) && (sr_a != sa);
        c_wr  = (op == TY_ADD) || (op == TY_ADDX);
      end
      TY_SUB, TY_SUBX, TY_CMP, TY_NEG, TY_DEC, TY_SUBS: begin
        r     = (op == TY_CMP) ? am : dif[31:0];
        c_out = |(dif & cm);
        v_out = (sa != sb) && (sr_s != sa);
        c_wr  = (op != TY_DEC) && (op != TY_SUBS);
      end
      TY_DADJ_ADD: begin
        r     = {24'h00_0000, am[7:0] + fix};
        c_out = hi_fix;
        c_wr  = 1'b1;
      end
      TY_DADJ_SUB: begin
        r     = {24'h00_0000, am[7:0] - fix};
        c_out = hi_fix;
        c_wr  = 1'b1;
      end
      TY_EXTU: r = am & lm;
      TY_EXTS: r = (am & lm) | (es ? (msk & ~lm) : '0);
      TY_TSET: r = am | TOP_BYTE;
      TY_AND:  r = am & bm;
      TY_OR:   r = am | bm;
      TY_XOR:  r = am ^ bm;
      TY_NOT:  r = ~am;
      TY_SHAL, TY_SHLL, TY_ROTL, TY_ROTXL: begin
        r     = (am << 1) | {31'h0000_0000, (op == TY_ROTL) ? msb : (op == TY_ROTXL) & c_in};
        c_out = msb;
        c_wr  = 1'b1;
      end
      TY_SHAR, TY_SHLR, TY_ROTR, TY_ROTXR: begin
        r = (am >> 1) | (((op == TY_SHAR) && msb) || ((op == TY_ROTR) && lsb) ||
                         ((op == TY_ROTXR) && c_in) ? top : '0);
        c_out = lsb;
        c_wr  = 1'b1;
      end
      TY_BSET: r = am | bx;
      TY_BCLR: r = am & ~bx;
      TY_BNOT: r = am ^ bx;
      TY_BST:  r = c_in ? (am | bx) : (am & ~bx);
      TY_BIST: r = c_in ? (am & ~bx) : (am | bx);
      TY_BLD, TY_BILD, TY_BAND, TY_BIAND, TY_BOR, TY_BIOR, TY_BXOR, TY_BIXOR: begin
        c_wr = 1'b1;
        unique case (op)
          TY_BLD:   c_out = bv;
          TY_BILD:  c_out = ~bv;
          TY_BAND:  c_out = c_in & bv;
          TY_BIAND: c_out = c_in & ~bv;
          TY_BOR:   c_out = c_in | bv;
          TY_BIOR:  c_out = c_in | ~bv;
          TY_BXOR:  c_out = c_in ^ bv;
          default:  c_out = c_in ^ ~bv;
        endcase
      end
      default: r = am;
    endcase
  end

  // Narrow results keep the upper part of the register
  assign result = (src_a & ~msk) | (r & msk);
  assign v_wr   = is_ar;
endmodule
`default_nettype wire

// ### src/cfr_core.sv
// CPU core slice: low condition flags, reset vector fetch, alignment, stack and decode
`timescale 1ns/1ps
`default_nettype none
module cfr_core
  import cfr_pkg::*;
#(
  parameter logic [31:0] RESET_VEC_ADDR = 32'h0000_0000
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Reset vector read
  output logic             vec_rd_q,
  output logic      [31:0] vec_addr_q,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             running_q,
  // Program counter
  input  wire logic        pc_load,
  input  wire logic [31:0] pc_value,
  output logic      [31:0] fetch_addr_q,
  // Execute request
  input  wire logic        exec_valid,
  input  wire logic [6:0]  exec_type,
  input  wire cfr_size_t   exec_size,
  input  wire logic [31:0] exec_src_a,
  input  wire logic [31:0] exec_src_b,
  input  wire logic [2:0]  exec_bit_idx,
  input  wire logic [2:0]  exec_areg,
  input  wire logic [7:0]  exec_reg_list,
  output logic             exec_done_q,
  output logic      [31:0] exec_result_q,
  output cfr_group_t       exec_group_q,
  output logic             exec_illegal_q,
  output logic             exec_misuse_q,
  // Control registers
  output logic      [7:0]  cond_flags,
  output logic             ext_trace_q,
  output logic      [2:0]  ext_imask_q,
  // Data address path
  input  wire logic        addr_valid,
  input  wire logic [31:0] addr_in,
  input  wire cfr_size_t   addr_size,
  output logic             data_valid_q,
  output logic      [31:0] data_addr_q,
  // Stack
  input  wire logic        sp_load,
  input  wire logic [31:0] sp_value,
  input  wire logic        stack_push,
  input  wire logic        stack_pop,
  input  wire cfr_size_t   stack_size,
  output logic             stack_valid_q,
  output logic      [31:0] stack_addr_q,
  output logic             stack_misuse_q,
  output logic      [31:0] sp_q,
  // Interrupts
  input  wire logic        irq_req,
  input  wire logic        nmi_req,
  output logic             irq_take_q
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] size_bytes(input cfr_size_t s);
    logic [31:0] n;
    n = BYTES_LONG;
    if (s == SZ_BYTE) begin
      n = BYTES_BYTE;
    end else if (s == SZ_WORD) begin
      n = BYTES_WORD;
    end
    return n;
  endfunction

  // Odd addresses are rounded down instead of faulting
  function automatic logic [31:0] align_even(input logic [31:0] a);
    return a & ALIGN_MASK;
  endfunction

  // Range decode: types are numbered group by group
  function automatic cfr_group_t group_of(input logic [6:0] t);
    cfr_group_t g;
    g = GR_NONE;
    if (t < GB_ARITH) begin
      g = GR_XFER;
    end else if (t < GB_LOGIC) begin
      g = GR_ARITH;
    end else if (t < GB_SHIFT) begin
      g = GR_LOGIC;
    end else if (t < GB_BIT) begin
      g = GR_SHIFT;
    end else if (t < GB_BRANCH) begin
      g = GR_BIT;
    end else if (t < GB_SYS) begin
      g = GR_BRANCH;
    end else if (t < GB_BLOCK) begin
      g = GR_SYS;
    end else if (t < TY_COUNT) begin
      g = GR_BLOCK;
    end
    return g;
  endfunction

  // ---------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------
  cfr_state_t  st_q;
  logic        mask_i_q;
  logic [6:0]  flags_lo_q;
  logic [7:0]  flags_q, flags_d;
  logic [31:0] alu_res, res_d, sp_dec, sp_inc;
  logic        alu_c, alu_v, alu_c_wr, alu_v_wr;
  logic        illegal_d, exec_fire, irq_take_d, misuse_d;
  cfr_group_t  group_d;

  assign flags_q    = {mask_i_q, flags_lo_q};
  assign cond_flags = flags_q;

  // ---------------------------------------------------------------
  // Reset exception sequencer
  // ---------------------------------------------------------------
  // Vector read stands until the memory answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q       <= ST_VEC;
      vec_rd_q   <= 1'b1;
      vec_addr_q <= RESET_VEC_ADDR;
      running_q  <= 1'b0;
    end else if (ce) begin
      unique case (st_q)
        ST_VEC: begin
          if (mem_ack) begin
            st_q      <= ST_RUN;
            vec_rd_q  <= 1'b0;
            running_q <= 1'b1;
          end
        end
        ST_RUN: begin
          vec_rd_q <= 1'b0;
        end
      endcase
    end
  end

  // Program counter is kept even, so every fetch starts on a word boundary
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_addr_q <= '0;
    end else if (ce) begin
      if (st_q == ST_VEC && mem_ack) begin
        fetch_addr_q <= align_even(mem_rdata);
      end else if (running_q && pc_load) begin
        fetch_addr_q <= align_even(pc_value);
      end
    end
  end

  // ---------------------------------------------------------------
  // Decode and execute
  // ---------------------------------------------------------------
  cfr_alu u_alu (
    .op      (exec_type),
    .size    (exec_size),
    .src_a   (exec_src_a),
    .src_b   (exec_src_b),
    .c_in    (flags_q[FLAG_C]),
    .h_in    (flags_q[FLAG_H]),
    .bit_idx (exec_bit_idx),
    .result  (alu_res),
    .c_out   (alu_c),
    .v_out   (alu_v),
    .c_wr    (alu_c_wr),
    .v_wr    (alu_v_wr)
  );

  // Peripheral byte transfers are refused so they never touch state
  assign group_d   = group_of(exec_type);
  assign illegal_d = (group_d == GR_NONE) || (exec_type == TY_PRD) ||
                     (exec_type == TY_PWR);
  assign exec_fire = exec_valid && running_q && !illegal_d;
  assign res_d     = (exec_type == TY_STC) ? {24'h00_0000, flags_q} : alu_res;

  // Misuse is reported only; the hardware still executes as told
  always_comb begin
    misuse_d = 1'b0;
    if (exec_type == TY_TSET && !TSET_REG_OK[exec_areg]) begin
      misuse_d = 1'b1;
    end
    if ((exec_type == TY_MLOAD || exec_type == TY_MSTORE) && exec_reg_list[SP_REG_IDX]) begin
      misuse_d = 1'b1;
    end
  end

  // Result and status of each request, one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_done_q    <= 1'b0;
      exec_result_q  <= '0;
      exec_group_q   <= GR_NONE;
      exec_illegal_q <= 1'b0;
      exec_misuse_q  <= 1'b0;
    end else if (ce) begin
      exec_done_q <= exec_valid && running_q;
      if (exec_valid && running_q) begin
        exec_result_q  <= illegal_d ? exec_src_a : res_d;
        exec_group_q   <= group_d;
        exec_illegal_q <= illegal_d;
        exec_misuse_q  <= misuse_d;
      end
    end
  end

  // ---------------------------------------------------------------
  // Condition flags and extended control
  // ---------------------------------------------------------------
  // The mask holds off all but the nonmaskable request
  assign irq_take_d = running_q && (nmi_req || (irq_req && !mask_i_q));

  // Datapath writes, then explicit loads, then exception entry
  always_comb begin
    flags_d = flags_q;
    if (exec_fire) begin
      if (alu_c_wr) begin
        flags_d[FLAG_C] = alu_c;
      end
      if (alu_v_wr) begin
        flags_d[FLAG_V] = alu_v;
      end
      case (exec_type)
        TY_LDC:   flags_d = exec_src_a[7:0];
        TY_ANDC:  flags_d = flags_q & exec_src_a[7:0];
        TY_ORC:   flags_d = flags_q | exec_src_a[7:0];
        TY_XORC:  flags_d = flags_q ^ exec_src_a[7:0];
        TY_TRAPA: flags_d[FLAG_I] = 1'b1;
        default:  flags_d = flags_d;
      endcase
    end
    if (irq_take_d) begin
      flags_d[FLAG_I] = 1'b1;
    end
  end

  // Only the mask bit has a reset value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_i_q <= FLAG_I_RST;
    end else if (ce) begin
      mask_i_q <= flags_d[FLAG_I];
    end
  end

  // No reset: these bits are undefined until software writes them
  always_ff @(posedge clk) begin
    if (ce) begin
      flags_lo_q <= flags_d[FLAG_I-1:0];
    end
  end

  // Extended control keeps its reset state; its writers lie outside this slice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_trace_q <= TRACE_RST;
      ext_imask_q <= IMASK_RST;
    end
  end

  // Interrupt acceptance, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_take_q <= 1'b0;
    end else if (ce) begin
      irq_take_q <= irq_take_d;
    end
  end

  // ---------------------------------------------------------------
  // Data addresses and stack
  // ---------------------------------------------------------------
  // Byte accesses keep their address; wider ones drop bit zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_valid_q <= 1'b0;
      data_addr_q  <= '0;
    end else if (ce) begin
      data_valid_q <= addr_valid && running_q;
      if (addr_valid && running_q) begin
        data_addr_q <= (addr_size == SZ_BYTE) ? addr_in : align_even(addr_in);
      end
    end
  end

  assign sp_dec = sp_q - size_bytes(stack_size);
  assign sp_inc = sp_q + size_bytes(stack_size);

  // Stack pointer has no reset: garbage until software loads it
  always_ff @(posedge clk) begin
    if (ce) begin
      if (sp_load) begin
        sp_q <= sp_value;
      end else if (stack_push && running_q) begin
        sp_q <= sp_dec;
      end else if (stack_pop && running_q) begin
        sp_q <= sp_inc;
      end
    end
  end

  // Push addresses the decremented pointer, pop the current one; push wins a tie
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stack_valid_q  <= 1'b0;
      stack_addr_q   <= '0;
      stack_misuse_q <= 1'b0;
    end else if (ce) begin
      stack_valid_q <= (stack_push || stack_pop) && running_q && !sp_load;
      if ((stack_push || stack_pop) && running_q && !sp_load) begin
        stack_addr_q   <= align_even(stack_push ? sp_dec : sp_q);
        stack_misuse_q <= (stack_size == SZ_BYTE);
      end
    end
  end

endmodule
`default_nettype wire

// ### test/cfr_core_props.sv
// Concurrent checks on the core ports
`timescale 1ns/1ps
`default_nettype none
module cfr_core_props
  import cfr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic        vec_rd_q,
  input wire logic        running_q,
  input wire logic [31:0] fetch_addr_q,
  input wire logic        exec_valid,
  input wire logic [6:0]  exec_type,
  input wire cfr_size_t   exec_size,
  input wire logic [31:0] exec_src_a,
  input wire logic [31:0] exec_src_b,
  input wire logic        exec_done_q,
  input wire logic [7:0]  cond_flags,
  input wire logic        addr_valid,
  input wire logic [31:0] addr_in,
  input wire cfr_size_t   addr_size,
  input wire logic [31:0] data_addr_q,
  input wire logic        irq_req,
  input wire logic        nmi_req,
  input wire logic        irq_take_q
);
  // ----------------
  // Helpers
  // ----------------
  // Byte add reference, independent of the datapath
  wire logic [8:0] sum9 = {1'b0, exec_src_a[7:0]} + {1'b0, exec_src_b[7:0]};
  wire logic       ovf  = (exec_src_a[7] == exec_src_b[7]) && (sum9[7] != exec_src_a[7]);
  wire logic       go   = running_q && ce;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_VEC_LOAD: assert property (vec_rd_q && ce && mem_ack |=>
    running_q && !vec_rd_q && fetch_addr_q == ($past(mem_rdata) & ALIGN_MASK))
    else $error("vector load wrong");
  AST_RESET_MASK: assert property (!running_q |-> cond_flags[FLAG_I])
    else $error("mask bit not set after reset");
  AST_DATA_EVEN: assert property (go && addr_valid && addr_size != SZ_BYTE |=>
    data_addr_q == ($past(addr_in) & ALIGN_MASK)) else $error("wide address not aligned");
  AST_DATA_BYTE: assert property (go && addr_valid && addr_size == SZ_BYTE |=>
    data_addr_q == $past(addr_in)) else $error("byte address altered");
  AST_EXEC_DONE: assert property (go |=> exec_done_q == $past(exec_valid))
    else $error("done pulse wrong");
  AST_ADD_FLAGS: assert property (go && exec_valid && exec_type == TY_ADD &&
    exec_size == SZ_BYTE |=> cond_flags[FLAG_C] == $past(sum9[8]) &&
    cond_flags[FLAG_V] == $past(ovf)) else $error("add flags wrong");
  AST_NMI: assert property (go && nmi_req |=> irq_take_q)
    else $error("nonmaskable not taken");
  AST_MASKED: assert property (go && irq_req && !nmi_req && cond_flags[FLAG_I] |=>
    !irq_take_q) else $error("masked interrupt taken");

  COV_VEC: cover property (vec_rd_q && mem_ack);
  COV_ADD: cover property (go && exec_valid && exec_type == TY_ADD);
  COV_IRQ: cover property (go && irq_req && !cond_flags[FLAG_I]);
endmodule

bind cfr_core cfr_core_props chk_u (.*);
`default_nettype wire

// ### test/cfr_mem_model.sv
// Vector table memory that answers the reset vector read
`timescale 1ns/1ps
`default_nettype none
module cfr_mem_model #(
  parameter int          DELAY    = 2,
  parameter logic [31:0] VEC_DATA = 32'h0000_1235
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        vec_rd_q,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  int cnt;
  // Answer once, DELAY+1 cycles after the read starts; the bus toggles otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt       <= 0;
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
    end else begin
      cnt       <= vec_rd_q ? cnt + 1 : 0;
      mem_ack   <= vec_rd_q && cnt == DELAY;
      mem_rdata <= (vec_rd_q && cnt == DELAY) ? VEC_DATA : ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ### test/cfr_core_tb_top.sv
// Self-checking bench for the core
`timescale 1ns/1ps
`default_nettype none
module cfr_core_tb_top;
  import cfr_pkg::*;
  // ----------------
  // Signals
  // ----------------
  logic clk = 0, rst = 1, mem_ack, pc_load = 0, exec_valid = 0, addr_valid = 0, sp_load = 0;
  logic stack_push = 0, stack_pop = 0, ce = 1, irq_req = 0, nmi_req = 0, vec_rd_q, running_q;
  logic exec_done_q, exec_illegal_q, exec_misuse_q, ext_trace_q, data_valid_q;
  logic stack_valid_q, stack_misuse_q, irq_take_q;
  logic [31:0] mem_rdata, vec_addr_q, fetch_addr_q, exec_result_q, data_addr_q, stack_addr_q;
  logic [31:0] pc_value = 0, exec_src_a = 0, exec_src_b = 0, addr_in = 0, sp_value = 0, sp_q;
  logic [6:0] exec_type = 0;
  logic [2:0] exec_bit_idx = 0, exec_areg = 0, ext_imask_q;
  logic [7:0] exec_reg_list = 0, cond_flags;
  cfr_size_t exec_size = SZ_BYTE, addr_size = SZ_BYTE, stack_size = SZ_BYTE;
  cfr_group_t exec_group_q;
  int failures = 0, checks_done = 0, i;

  always #5 clk = ~clk;
  // Slow answer, so the core must wait for the vector
  cfr_mem_model #(.DELAY(3)) mem_u (.*);
  cfr_core dut_u (.*);

  // ----------------
  // Tasks
  // ----------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h got %h", n, e, g);
      failures++;
    end
  endtask
  // One execute request, sampled mid-cycle during the done pulse
  task automatic ex(input logic [6:0] t, input cfr_size_t s, input logic [31:0] a = 0, b = 0,
                    input logic [2:0] bi = 0, ar = 0, input logic [7:0] rl = 0);
    @(posedge clk);
    exec_valid <= 1;
    exec_type <= t;
    exec_size <= s;
    exec_src_a <= a;
    exec_src_b <= b;
    exec_bit_idx <= bi;
    exec_areg <= ar;
    exec_reg_list <= rl;
    @(posedge clk);
    exec_valid <= 0;
    @(negedge clk);
    chk("done", 1, exec_done_q);
  endtask
  task automatic ad(input logic [31:0] a, input cfr_size_t s, input logic [31:0] e);
    @(posedge clk);
    addr_valid <= 1;
    addr_in <= a;
    addr_size <= s;
    @(posedge clk);
    addr_valid <= 0;
    @(negedge clk);
    chk("data_addr", e, data_addr_q);
    chk("data_valid", 1, data_valid_q);
  endtask
  task automatic st(input logic psh, input cfr_size_t s, input logic [31:0] ea, es);
    @(posedge clk);
    stack_push <= psh;
    stack_pop <= !psh;
    stack_size <= s;
    @(posedge clk);
    stack_push <= 0;
    stack_pop <= 0;
    @(negedge clk);
    chk("stack_addr", ea, stack_addr_q);
    chk("sp", es, sp_q);
    chk("stack_misuse", s == SZ_BYTE, stack_misuse_q);
    chk("stack_valid", ce, stack_valid_q);
  endtask
  // Group bounds: running totals of group sizes
  function automatic logic [31:0] exp_grp(input int t);
    int b[8] = '{5, 24, 28, 36, 50, 55, 64, 65};
    for (int k = 0; k < 8; k++) if (t < b[k]) return k;
    return 8;
  endfunction
  task automatic results;
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    @(negedge clk);
    chk("mask_i", 1, cond_flags[FLAG_I]);
    chk("trace", 0, ext_trace_q);
    chk("imask", 7, ext_imask_q);
    chk("vec_addr", 0, vec_addr_q);
    for (i = 0; i < 20 && !running_q; i++) @(negedge clk);
    chk("fetch", 32'h0000_1234, fetch_addr_q);
    @(posedge clk);
    pc_load <= 1;
    pc_value <= 32'h0000_0005;
    sp_load <= 1;
    sp_value <= 32'h0000_0100;
    @(posedge clk);
    pc_load <= 0;
    sp_load <= 0;
    @(negedge clk);
    chk("pc", 32'h0000_0004, fetch_addr_q);
    st(1, SZ_LONG, 32'h0000_00FC, 32'h0000_00FC);
    st(0, SZ_WORD, 32'h0000_00FC, 32'h0000_00FE);
    st(1, SZ_BYTE, 32'h0000_00FC, 32'h0000_00FD);
    @(posedge clk);
    ce <= 0;
    st(0, SZ_BYTE, 32'h0000_00FC, 32'h0000_00FD);
    @(posedge clk);
    ce <= 1;
    ad(32'h0000_1003, SZ_WORD, 32'h0000_1002);
    ad(32'h0000_1003, SZ_LONG, 32'h0000_1002);
    ad(32'h0000_1003, SZ_BYTE, 32'h0000_1003);
    ex(TY_ADD, SZ_BYTE, 32'h0000_00FF, 32'h0000_0001);
    chk("c_add", 1, cond_flags[FLAG_C]);
    chk("v_add", 0, cond_flags[FLAG_V]);
    ex(TY_ADD, SZ_BYTE, 32'h0000_007F, 32'h0000_0001);
    chk("v_ovf", 1, cond_flags[FLAG_V]);
    chk("res_ovf", 32'h0000_0080, exec_result_q[7:0]);
    ex(TY_ADD, SZ_LONG, 32'hFFFF_FFFF, 32'h0000_0001);
    chk("c_long", 1, cond_flags[FLAG_C]);
    ex(TY_SUB, SZ_BYTE, 32'h0000_0000, 32'h0000_0001);
    chk("c_borrow", 1, cond_flags[FLAG_C]);
    ex(TY_SHLL, SZ_BYTE, 32'h0000_0080);
    chk("c_shift", 1, cond_flags[FLAG_C]);
    ex(TY_ADD, SZ_BYTE, 32'h0000_0009, 32'h0000_0001);
    ex(TY_DADJ_ADD, SZ_BYTE, 32'h0000_000A);
    chk("bcd", 32'h0000_0010, exec_result_q[7:0]);
    ex(TY_BLD, SZ_BYTE, 32'h0000_0080, 32'h0000_0000, 3'd7);
    chk("c_bit7", 1, cond_flags[FLAG_C]);
    ex(TY_BLD, SZ_BYTE, 32'h0000_007F, 32'h0000_0000, 3'd7);
    chk("c_bit7", 0, cond_flags[FLAG_C]);
    for (i = 0; i < 66; i++) begin
      ex(i[6:0], SZ_BYTE);
      chk("group", exp_grp(i), exec_group_q);
      chk("illegal", i == 3 || i == 4 || i == 65, exec_illegal_q);
    end
    for (i = 0; i < 8; i++) begin
      ex(TY_TSET, SZ_BYTE, 32'h0000_0000, 32'h0000_0000, 3'd0, i[2:0]);
      chk("tset_misuse", !(i == 0 || i == 1 || i == 4 || i == 5), exec_misuse_q);
    end
    ex(TY_MLOAD, SZ_LONG, 32'h0000_0000, 32'h0000_0000, 3'd0, 3'd0, 8'h80);
    chk("list_misuse", 1, exec_misuse_q);
    ex(TY_MSTORE, SZ_LONG, 32'h0000_0000, 32'h0000_0000, 3'd0, 3'd0, 8'h06);
    chk("list_misuse", 0, exec_misuse_q);
    ex(TY_LDC, SZ_BYTE);
    @(posedge clk);
    irq_req <= 1;
    repeat (2) @(negedge clk);
    chk("irq_take", 1, irq_take_q);
    @(negedge clk);
    chk("irq_masked", 0, irq_take_q);
    @(posedge clk);
    nmi_req <= 1;
    @(posedge clk);
    nmi_req <= 0;
    irq_req <= 0;
    @(negedge clk);
    chk("nmi_take", 1, irq_take_q);
    results();
  end

  // Hang guard, far past the sequence length
  initial begin
    #20us;
    failures++;
    results();
  end
endmodule
`default_nettype wire
